//--- qdc_top.sv
// Eight-group converter control block with APB register slave
//
// Local design decision: the APB interface to the registers.
`default_nettype none
module qdc_top (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] xfer_done_i,
  input wire logic [7:0] load_cmd_i,
  input wire logic [7:0] seq_update_i,
  input wire logic [7:0] busy_i,
  input wire logic [7:0] fetch_ack_i,
  input wire logic [79:0] fetch_data_i,
  input wire logic [23:0] irq_raw_i,
  input wire logic stat_ready_i,
  output logic [7:0] fetch_start_o,
  output logic [7:0] update_o,
  output logic [23:0] irq_o,
  output logic stat_valid_o,
  output logic [9:0] stat_data_o
);
  import qdc_pkg::*;
  qdc_ctrl_s ctrl_q [NUM_GROUPS];
  qdc_ctrl_s ctrl_d [NUM_GROUPS];
  logic [15:0] atmr_q, atmr_d, acnt_q, acnt_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic acc, wr;
  logic [7:0] freq, grp_valid, gload_mask;
  logic [79:0] stat_flat;
  logic tick, gload;
  logic [7:0] fs_raw;
  logic bin_ready;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = err_q;
  assign tick = acnt_q == 16'h0000;

  // Global load fires when every shared group has its data in and its load command
  always_comb begin
    gload = 1'b0;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      gload_mask[g] = ctrl_q[g].mode == MODE_MANUAL
        && ctrl_q[g].shared_update_select;
    end
    if (gload_mask != 8'h00) begin
      gload = ((xfer_done_i & load_cmd_i & gload_mask) == gload_mask); // RQ4
    end
  end

  // ===========================================================
  // Register writes
  always_comb begin
    ctrl_d = ctrl_q;
    atmr_d = atmr_q;
    acnt_d = tick ? atmr_q : acnt_q - 16'h0001;
    freq = 8'h00;
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (wr && paddr == CTRL_BASE + 12'(g) * GRP_STRIDE) begin
        ctrl_d[g].shared_update_select = pwdata[SHARED_BIT];
        ctrl_d[g].auto_status_poll = pwdata[AUTO_BIT];
        ctrl_d[g].sequencer_irq_enable = pwdata[SEQ_IRQ_BIT];
        ctrl_d[g].alert_irq_enable = pwdata[ALERT_IRQ_BIT];
        ctrl_d[g].load_irq_enable = pwdata[LOAD_IRQ_BIT];
        ctrl_d[g].mode = qdc_mode_e'(pwdata[1:0]); // RQ11
        // Playback codes have bit 1 set: request ignored there
        freq[g] = pwdata[FETCH_REQ_BIT] && !pwdata[1]; // RQ1
      end
    end
    if (wr && paddr == ATMR_OFF) begin
      atmr_d = pwdata[15:0];
    end
  end

  // ===========================================================
  // Register reads
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    // Captured in setup so that it stands at the access edge
    if (psel && !penable && !pwrite) begin
      if (paddr == ATMR_OFF) begin
        rdata_d = {16'h0000, atmr_q};
      end else if (paddr >= CTRL_BASE && paddr < STAT_BASE
                   && paddr[1:0] == 2'h0) begin
        rdata_d = {22'h000000, 1'b0, ctrl_q[paddr[4:2]].shared_update_select,
                   ctrl_q[paddr[4:2]].auto_status_poll, 1'b0,
                   ctrl_q[paddr[4:2]].sequencer_irq_enable,
                   ctrl_q[paddr[4:2]].alert_irq_enable,
                   ctrl_q[paddr[4:2]].load_irq_enable, 1'b0,
                   ctrl_q[paddr[4:2]].mode}; // RQ15
      end else if (paddr >= STAT_BASE && paddr < ATMR_OFF
                   && paddr[1:0] == 2'h0) begin
        rdata_d = {21'h000000, grp_valid[paddr[4:2]],
                   stat_flat[10 * paddr[4:2] +: 10]};
      end else begin
        err_d = 1'b1;
      end
    end else if (psel && !penable && pwrite) begin
      err_d = !((paddr >= CTRL_BASE && paddr < STAT_BASE
                 && paddr[1:0] == 2'h0) || paddr == ATMR_OFF);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        ctrl_q[g] <= qdc_ctrl_s'(7'h00);
      end
      atmr_q <= ATMR_RESET;
      acnt_q <= ATMR_RESET;
      rdata_q <= CTRL_RESET;
      err_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      atmr_q <= atmr_d;
      acnt_q <= acnt_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // ===========================================================
  // Groups
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp // RQ17
    qdc_group u_grp (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .ctrl_i(ctrl_q[g]),
      .fetch_req_i(freq[g]),
      .auto_tick_i(tick),
      .seq_update_i(seq_update_i[g]),
      .xfer_done_i(xfer_done_i[g]),
      .load_cmd_i(load_cmd_i[g]),
      .global_load_i(gload),
      .busy_i(busy_i[g]),
      .fetch_ack_i(fetch_ack_i[g]),
      .fetch_data_i(fetch_data_i[10 * g +: 10]),
      .irq_raw_i(irq_raw_i[3 * g +: 3]),
      .fetch_start_o(fs_raw[g]),
      .update_o(update_o[g]),
      .status_valid_o(grp_valid[g]),
      .status_o(stat_flat[10 * g +: 10]),
      .irq_o(irq_o[3 * g +: 3])
    );
  end

  assign fetch_start_o = fs_raw;

  // Stream of fetched status words, lowest acknowledging group
  logic [9:0] bin_data;
  logic bin_valid;
  always_comb begin
    bin_valid = 1'b0;
    bin_data = 10'h000;
    for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
      if (fetch_ack_i[g]) begin
        bin_valid = 1'b1;
        bin_data = fetch_data_i[10 * g +: 10];
      end
    end
  end

  qdc_buf2 u_buf (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(bin_valid),
    .in_ready_o(bin_ready),
    .in_data_i(bin_data),
    .out_valid_o(stat_valid_o),
    .out_ready_i(stat_ready_i),
    .out_data_o(stat_data_o)
  );
endmodule
`default_nettype wire

//--- qdc_pkg.sv
// Package: constants, types and the block's behaviour list for qdc control
// What this block does
// [RQ1] Status fetch request bit 9 honoured only in instant/manual mode, self-clearing.
// [RQ2] Request clears status valid; completed fetch updates status and sets valid.
// [RQ3] Fetch may wait until converter activity ends; request stays pending.
// [RQ4] Manual mode, shared bit 8 set: update with all shared-update groups.
// [RQ5] Manual mode, shared bit clear: group updates alone after data transfer.
// [RQ6] Auto status bit 7 enables periodic status reads via auto status timer.
// [RQ7] Playback modes with auto status: one read per sequence, ~10us after update.
// [RQ8] Sequencer interrupts pass only while bit 5 set.
// [RQ9] Alert interrupts pass only while bit 4 set.
// [RQ10] Load interrupts pass only while bit 3 set.
// [RQ11] Mode bits 1:0 reset to 00; instant mode updates after each transfer.
// [RQ12] Mode 01 manual: outputs update together on software load command.
// [RQ13] Mode 10 FIFO playback: sequencer timer drives transfer and update.
// [RQ14] Mode 11 timer playback: sequencer timer, data from internal RAM.
// [RQ15] Reserved bits 31:10, 6, 2 written zero; read back as zero here.
// [RQ16] Status register changes only after requested fetch or auto reads.
// [RQ17] Eight independent control register instances, one per group.
`default_nettype none
package qdc_pkg;
  localparam int NUM_GROUPS = 8;
  localparam logic [11:0] CTRL_BASE = 12'h020;
  localparam logic [11:0] STAT_BASE = 12'h040;
  localparam logic [11:0] ATMR_OFF = 12'h060;
  localparam logic [11:0] GRP_STRIDE = 12'h004;
  localparam int FETCH_REQ_BIT = 9;
  localparam int SHARED_BIT = 8;
  localparam int AUTO_BIT = 7;
  localparam int SEQ_IRQ_BIT = 5;
  localparam int ALERT_IRQ_BIT = 4;
  localparam int LOAD_IRQ_BIT = 3;
  localparam int VALID_BIT = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] ATMR_RESET = 16'h0fa0;
  localparam int CLK_MHZ = 40;
  localparam int SEQ_DELAY_US = 10;
  localparam int SEQ_DELAY_CYC = SEQ_DELAY_US * CLK_MHZ;
  localparam logic [8:0] SEQ_DELAY_CNT = 9'(SEQ_DELAY_CYC);

  typedef enum logic [1:0] {
    MODE_INSTANT = 2'h0,
    MODE_MANUAL = 2'h1,
    MODE_FIFO = 2'h2,
    MODE_TIMER = 2'h3
  } qdc_mode_e;

  typedef struct packed {
    logic shared_update_select;
    logic auto_status_poll;
    logic sequencer_irq_enable;
    logic alert_irq_enable;
    logic load_irq_enable;
    qdc_mode_e mode;
  } qdc_ctrl_s;

  typedef struct packed {
    logic seq;
    logic alert;
    logic load;
  } qdc_irq_s;

  typedef struct packed {
    logic [9:0] bits;
  } qdc_status_s;
endpackage
`default_nettype wire

//--- qdc_buf2.sv
// Two-entry valid/ready buffer for fetched status words
`default_nettype none
module qdc_buf2 (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [9:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [9:0] out_data_o
);
  logic [9:0] mem_q [2];
  logic [9:0] mem_d [2];
  logic rd_q, rd_d, wr_q, wr_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = cnt_q != 2'h2;
  assign out_valid_o = cnt_q != 2'h0;
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    mem_d = mem_q;
    if (push) begin
      mem_d[wr_q] = in_data_i;
    end
    wr_d = push ? ~wr_q : wr_q;
    rd_d = pop ? ~rd_q : rd_q;
    cnt_d = cnt_q + 2'(push) - 2'(pop);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mem_q[0] <= 10'h000;
      mem_q[1] <= 10'h000;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

//--- qdc_group.sv
// One converter group: status fetch scheduling and update/interrupt gating
`default_nettype none
module qdc_group (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire qdc_pkg::qdc_ctrl_s ctrl_i,
  input wire logic fetch_req_i,
  input wire logic auto_tick_i,
  input wire logic seq_update_i,
  input wire logic xfer_done_i,
  input wire logic load_cmd_i,
  input wire logic global_load_i,
  input wire logic busy_i,
  input wire logic fetch_ack_i,
  input wire logic [9:0] fetch_data_i,
  input wire qdc_pkg::qdc_irq_s irq_raw_i,
  output logic fetch_start_o,
  output logic update_o,
  output logic status_valid_o,
  output qdc_pkg::qdc_status_s status_o,
  output qdc_pkg::qdc_irq_s irq_o
);
  import qdc_pkg::*;
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_FETCH} qdc_fetch_e;
  qdc_fetch_e st_q, st_d;
  logic valid_q, valid_d;
  logic [9:0] stat_q, stat_d;
  logic [8:0] dly_q, dly_d;
  logic dly_run_q, dly_run_d;
  logic pend_q, pend_d;
  logic upd_d, upd_q;
  logic man, play;

  assign man = ctrl_i.mode == MODE_MANUAL;
  assign play = ctrl_i.mode == MODE_FIFO || ctrl_i.mode == MODE_TIMER;

  always_comb begin
    upd_d = 1'b0;
    if (ctrl_i.mode == MODE_INSTANT) begin
      upd_d = xfer_done_i; // RQ11
    end else if (man && ctrl_i.shared_update_select) begin
      upd_d = global_load_i; // RQ4
    end else if (man) begin
      upd_d = load_cmd_i && xfer_done_i; // RQ5 RQ12
    end else begin
      upd_d = seq_update_i; // RQ13 RQ14
    end
  end

  always_comb begin
    st_d = st_q;
    valid_d = valid_q;
    stat_d = stat_q;
    pend_d = pend_q;
    dly_d = dly_q;
    dly_run_d = dly_run_q;
    fetch_start_o = 1'b0;
    if (play && ctrl_i.auto_status_poll && upd_q) begin
      dly_run_d = 1'b1; // RQ7
      dly_d = SEQ_DELAY_CNT;
    end else if (dly_run_q) begin
      dly_d = dly_q - 9'h001;
      if (dly_q == 9'h001) begin
        dly_run_d = 1'b0;
        pend_d = 1'b1; // RQ7
      end
    end
    if (!play && ctrl_i.auto_status_poll && auto_tick_i) begin
      pend_d = 1'b1; // RQ6
    end
    if (fetch_req_i) begin
      pend_d = 1'b1; // RQ1
      valid_d = 1'b0; // RQ2
    end
    case (st_q)
      S_IDLE: begin
        if (pend_q) begin
          st_d = S_WAIT;
        end
      end
      S_WAIT: begin
        if (!busy_i) begin
          st_d = S_FETCH; // RQ3
          fetch_start_o = 1'b1;
          if (!fetch_req_i) begin
            pend_d = 1'b0;
          end
        end
      end
      default: begin
        if (fetch_ack_i) begin
          st_d = S_IDLE;
          stat_d = fetch_data_i; // RQ16
          if (!fetch_req_i) begin
            valid_d = 1'b1; // RQ2
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_q <= S_IDLE;
      valid_q <= 1'b0;
      stat_q <= 10'h000;
      pend_q <= 1'b0;
      dly_q <= 9'h000;
      dly_run_q <= 1'b0;
      upd_q <= 1'b0;
    end else begin
      st_q <= st_d;
      valid_q <= valid_d;
      stat_q <= stat_d;
      pend_q <= pend_d;
      dly_q <= dly_d;
      dly_run_q <= dly_run_d;
      upd_q <= upd_d;
    end
  end

  assign update_o = upd_q;
  assign status_valid_o = valid_q;
  assign status_o.bits = stat_q;
  assign irq_o.seq = irq_raw_i.seq && ctrl_i.sequencer_irq_enable; // RQ8
  assign irq_o.alert = irq_raw_i.alert && ctrl_i.alert_irq_enable; // RQ9
  assign irq_o.load = irq_raw_i.load && ctrl_i.load_irq_enable; // RQ10
endmodule
`default_nettype wire

//--- qdc_top_props.sv
// Port-level properties of the converter control block
`default_nettype none
module qdc_top_props (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [7:0] busy_i,
  input wire logic [7:0] fetch_ack_i,
  input wire logic [23:0] irq_raw_i,
  input wire logic stat_ready_i,
  input wire logic [7:0] fetch_start_o,
  input wire logic [23:0] irq_o,
  input wire logic stat_valid_o,
  input wire logic [9:0] stat_data_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic acc = psel && penable;
  wire logic wr0 = acc && pwrite && paddr == 12'h020 && pwdata[9];
  wire logic wr2 = acc && pwrite && paddr == 12'h028 && pwdata[9];
  a_ready_high: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  a_fetch_wait: assert property ((fetch_start_o & busy_i) == 8'h00)
    else $error("status read started while busy");
  a_irq_gate: assert property ((irq_o & ~irq_raw_i) == 24'h0)
    else $error("interrupt without a raw source");
  a_ctrl_reserved: assert property (
    acc && !pwrite && paddr[11:5] == 7'h01 |-> (prdata & 32'hfffffe44) == 0)
    else $error("reserved control bits read nonzero");
  a_stat_hold: assert property (stat_valid_o && !stat_ready_i
    |=> stat_valid_o && $stable(stat_data_o))
    else $error("status word lost during stall");
  a_fetch_go: assert property (
    wr2 && !pwdata[1] && !busy_i[2] |-> ##[0:3] fetch_start_o[2])
    else $error("status request not started");
  a_fetch_skip: assert property (
    wr0 && pwdata[1] |=> !fetch_start_o[0] [*4])
    else $error("status request honoured in playback mode");
  a_ack_word: assert property (
    (|fetch_ack_i) && stat_ready_i && !stat_valid_o |-> ##[1:3] stat_valid_o)
    else $error("fetched status not delivered");
  a_stat_source: assert property ($rose(stat_valid_o) |->
    (|$past(fetch_ack_i)) || (|$past(fetch_ack_i, 2)))
    else $error("status word without a fetch");
endmodule
bind qdc_top qdc_top_props u_props (.*);
`default_nettype wire

//--- qdc_conv_model.sv
// Converter partner: answers status reads after a set latency
`default_nettype none
module qdc_conv_model #(
  parameter int LAT = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] fetch_start_i,
  input wire logic [7:0] hold_i,
  output logic [7:0] fetch_ack_o,
  output logic [7:0] busy_o,
  output logic [79:0] fetch_data_o
);
  int cnt[8];
  always_ff @(posedge ref_clk_i)
    for (int g = 0; g < 8; g++)
      if (!rst_n_i) cnt[g] <= 0;
      else if (fetch_start_i[g]) cnt[g] <= LAT;
      else if (cnt[g] > 0) cnt[g] <= cnt[g] - 1;
  // Data valid only in the ack cycle, 10'h15f otherwise
  always_comb
    for (int g = 0; g < 8; g++) begin
      fetch_ack_o[g] = cnt[g] == 1;
      busy_o[g] = hold_i[g] || cnt[g] > 0;
      fetch_data_o[g*10+:10] = fetch_ack_o[g] ? 10'h2a0 + 10'(g) : 10'h15f;
    end
endmodule
`default_nettype wire

//--- tb_qdc_top.sv
// Testbench: registers, status reads, interrupts and updates
`default_nettype none
module tb_qdc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import qdc_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, stat_ready_i = 1, stat_valid_o, err;
  logic [7:0] xfer = 0, load = 0, sequ = 0, hold = 0, busy, ack, fst, upd;
  logic [79:0] fdata;
  logic [23:0] irq_raw = 0, irq;
  logic [9:0] stat_data;
  int failures = 0, check_count = 0;
  qdc_top dut (.ref_clk_i, .rst_n_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .xfer_done_i(xfer),
    .load_cmd_i(load), .seq_update_i(sequ), .busy_i(busy),
    .fetch_ack_i(ack), .fetch_data_i(fdata), .irq_raw_i(irq_raw),
    .stat_ready_i, .fetch_start_o(fst), .update_o(upd), .irq_o(irq),
    .stat_valid_o, .stat_data_o(stat_data));
  qdc_conv_model #(.LAT(4)) conv (.ref_clk_i, .rst_n_i, .fetch_start_i(fst),
    .hold_i(hold), .fetch_ack_o(ack), .busy_o(busy), .fetch_data_o(fdata));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic pulse(input logic [7:0] x, l, input int g, output int n);
    xfer <= x;
    load <= l;
    @(posedge ref_clk_i);
    xfer <= 0;
    load <= 0;
    n = 0;
    repeat (6) begin
      @(posedge ref_clk_i);
      n += upd[g];
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_regs;
    for (int g = 0; g < 8; g++) begin
      apb(0, CTRL_BASE + 12'(4 * g), 0);
      chk(rd, 0, "ctrl reset");
      apb(1, CTRL_BASE + 12'(4 * g), 32'hffff_fffe ^ 32'(g & 1));
    end
    for (int g = 0; g < 8; g++) begin
      apb(0, CTRL_BASE + 12'(4 * g), 0);
      chk(rd, 32'h1ba ^ 32'(g & 1), "ctrl readback");
      apb(1, CTRL_BASE + 12'(4 * g), 0);
    end
    apb(0, 12'h100, 0);
    chk(32'(err), 1, "unmapped access");
    $display("test regs done");
  endtask
  task automatic t_fetch;
    int n;
    for (int r = 0; r < 2; r++) begin
      hold <= r ? 8'h00 : 8'h04;
      apb(1, CTRL_BASE + 12'h008, 32'h201);
      apb(0, CTRL_BASE + 12'h008, 0);
      chk(rd, 32'h1, "request bit stuck");
      repeat (20) @(posedge ref_clk_i);
      apb(0, STAT_BASE + 12'h008, 0);
      chk(rd, r ? 32'h6a2 : 0, "valid while pending");
      hold <= 0;
      n = 0;
      do begin
        apb(0, STAT_BASE + 12'h008, 0);
        n++;
      end while (rd[10] !== 1'b1 && n < 20);
      chk(rd, 32'h6a2, "fetched status");
    end
    $display("test fetch done");
  endtask
  task automatic t_auto;
    int n = 0;
    int w = 0;
    stat_ready_i <= 0;
    apb(1, ATMR_OFF, 32'd30);
    apb(1, CTRL_BASE + 12'h00c, 32'h80);
    // The reset reload runs out first, then the short period applies
    while (fst[3] !== 1'b1 && n < 5000) begin
      @(posedge ref_clk_i);
      n++;
    end
    n = 0;
    repeat (200) begin
      @(posedge ref_clk_i);
      n += fst[3];
    end
    chk(32'(n >= 5 && n <= 8), 1, "auto read count");
    chk(32'(stat_valid_o), 1, "buffer holds word");
    apb(1, CTRL_BASE + 12'h00c, 0);
    repeat (10) @(posedge ref_clk_i);
    stat_ready_i <= 1;
    n = 0;
    repeat (200) begin
      @(posedge ref_clk_i);
      n += fst[3];
      w += stat_valid_o & stat_ready_i;
    end
    chk(n, 0, "auto reads after disable");
    chk(w, 2, "buffered words");
    $display("test auto done");
  endtask
  task automatic t_irq;
    irq_raw <= 24'hffffff;
    for (int b = 3; b < 6; b++) begin
      apb(1, CTRL_BASE + 12'h004, 32'(1) << b);
      @(posedge ref_clk_i);
      chk(32'(irq), 32'(1) << b, "irq gating");
    end
    apb(1, CTRL_BASE + 12'h004, 0);
    irq_raw <= 0;
    $display("test irq done");
  endtask
  task automatic t_update;
    int n;
    for (int m = 0; m < 3; m++) begin
      apb(1, CTRL_BASE, 32'(m ? m + 1 : 0));
      n = 0;
      xfer <= m ? 8'h00 : 8'h01;
      sequ <= m ? 8'h01 : 8'h00;
      @(posedge ref_clk_i);
      xfer <= 0;
      sequ <= 0;
      repeat (6) begin
        @(posedge ref_clk_i);
        n += upd[0];
      end
      chk(n, 1, "update pulses");
    end
    apb(1, CTRL_BASE, 32'h1);
    pulse(8'h01, 8'h00, 0, n);
    chk(n, 0, "manual update without load");
    pulse(8'h01, 8'h01, 0, n);
    chk(n, 1, "manual standalone update");
    apb(1, CTRL_BASE, 32'h101);
    apb(1, CTRL_BASE + 12'h004, 32'h101);
    pulse(8'h01, 8'h01, 1, n);
    chk(n, 0, "shared update too early");
    pulse(8'h03, 8'h03, 1, n);
    chk(n, 1, "shared update");
    apb(1, CTRL_BASE + 12'h004, 0);
    apb(1, CTRL_BASE, 32'h82);
    sequ <= 1;
    @(posedge ref_clk_i);
    sequ <= 0;
    n = 0;
    while (fst[0] !== 1'b1 && n < 600) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk(32'(n > 380 && n < 420), 1, "status read delay");
    apb(1, CTRL_BASE, 0);
    $display("test update done");
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1;
    t_regs;
    t_fetch;
    t_auto;
    t_irq;
    t_update;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    failures++;
    stop_test;
  end
endmodule
`default_nettype wire
